// >>> src/prs_pkg.sv
// package: register map, field positions and reset values of the result block
package prs_pkg;
    localparam logic [7:0] ADDR_REF_LOW   = 8'h15;
    localparam logic [7:0] ADDR_REF_MID   = 8'h16;
    localparam logic [7:0] ADDR_REF_HIGH  = 8'h17;
    localparam logic [7:0] ADDR_OFS_LOW   = 8'h18;
    localparam logic [7:0] ADDR_OFS_HIGH  = 8'h19;
    localparam logic [7:0] ADDR_LP_CFG    = 8'h1A;
    localparam logic [7:0] ADDR_INT_ORIG  = 8'h25;
    localparam logic [7:0] ADDR_Q_STATUS  = 8'h26;
    localparam logic [7:0] ADDR_S_STATUS  = 8'h27;
    localparam logic [7:0] ADDR_RES_LOW   = 8'h28;
    localparam logic [7:0] ADDR_RES_MID   = 8'h29;
    localparam logic [7:0] ADDR_RES_HIGH  = 8'h2A;

    localparam int BIT_LOW_CURRENT_ENABLE       = 0;
    localparam int BIT_LP_RSVD     = 1;
    localparam int BIT_BOOT_STAT   = 7;
    localparam int BIT_INT_ACTIVE  = 2;
    localparam int BIT_P_LOW_EVT   = 1;
    localparam int BIT_P_HIGH_EVT  = 0;
    localparam int BIT_WATERMARK   = 7;
    localparam int BIT_Q_OVERWRITE = 6;
    localparam int BIT_T_OVERRUN   = 5;
    localparam int BIT_P_OVERRUN   = 4;
    localparam int BIT_T_AVAIL     = 1;
    localparam int BIT_P_AVAIL     = 0;

    localparam logic [23:0] RST_REFERENCE = 24'h000000;
    localparam logic [15:0] RST_OFFSET    = 16'h0000;
    localparam logic [7:0]  RST_LP_CFG    = 8'h00;
    localparam logic [23:0] RST_RESULT    = 24'h000000;
    localparam int          QUEUE_DEPTH   = 32;
endpackage : prs_pkg

// >>> src/prs_result_regs.sv
// result, reference, offset and status register set of the pressure readout
//
// Operation
// R1 - reference pressure is 24-bit signed, bytes at 17h, 16h, 15h
// R2 - reference used only while auto zeroing or reference restore is on
// R3 - 16-bit signed calibration offset, bytes at 19h and 18h
// R4 - low_current_enable bit 0, reset 0: normal low-noise, set: low-current
// R5 - host changes low_current_enable only while powered down
// R6 - low_current_enable applies to one-shot and continuous conversion alike
// R7 - host writes zeros to bits 7..2, keeps reserved bit 1
// R8 - interrupt origin bit 7 is one while boot is running
// R9 - interrupt_active bit 2 shows one or more events were generated
// R10 - bit 1 low pressure event, bit 0 high pressure event
// R11 - watermark_reached bit 7 set when fill reaches threshold
// R12 - queue_overwritten bit 6 when full and a sample was overwritten
// R13 - unread_sample_count six bits, 0 empty up to 32 full
// R14 - status bit 5 set when temperature sample overwrote unread one
// R15 - status bit 4 set when pressure sample overwrote unread one
// R16 - status bit 1 set when new temperature sample produced
// R17 - status bit 0 set when new pressure sample produced
// R18 - status register refreshed once every output data rate cycle
// R19 - 24-bit signed result at 2Ah high, 29h mid, 28h low
// R20 - without diff, zeroing or restore, result is measurement minus offset
// R21 - with block_update_hold, outputs freeze until high result byte read
// R22 - software reset returns the reference registers to defaults
// R23 - unused status bits read zero, writes to read-only registers ignored
// R24 - data-available flags clear once host reads the output data
`timescale 1ns/100ps
`default_nettype none

module prs_result_regs
    import prs_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int OFFSET_W = 16
) (
    input  wire logic                core_clk,         // 40 MHz clock
    input  wire logic                rst_b,            // sync reset, low
    input  wire logic                reg_wr,           // register write strobe
    input  wire logic                reg_rd,           // register read strobe
    input  wire logic [7:0]          reg_addr,         // register address
    input  wire logic [7:0]          reg_wdata,        // write data
    output logic      [7:0]          reg_rdata,        // read data
    input  wire logic                software_reset,   // soft reset pulse
    input  wire logic                block_update_hold,// freeze outputs
    input  wire logic                automatic_zeroing,// zeroing enabled
    input  wire logic                automatic_reference_restore, // restore
    input  wire logic                differential_enable, // diff enabled
    input  wire logic                odr_tick,         // one per OUTPUT_DATA_RATE cycle
    input  wire logic                p_sample_valid,   // new pressure sample
    input  wire logic [SAMPLE_W-1:0] p_measured,       // raw pressure
    input  wire logic                t_sample_valid,   // new temperature
    input  wire logic                t_data_read,      // host read temp out
    input  wire logic                boot_running,     // boot in progress
    input  wire logic                pressure_low_event,  // low event
    input  wire logic                pressure_high_event, // high event
    input  wire logic [5:0]          unread_sample_count, // queue fill
    input  wire logic [4:0]          watermark_level,  // queue threshold
    input  wire logic                queue_overwritten,// queue overwrote
    output logic                     low_current_enable, // mode select
    output logic                     reference_in_use, // reference selected
    output logic [SAMPLE_W-1:0]      reference_pressure_bits, // reference
    output logic [SAMPLE_W-1:0]      pressure_result_bits // result word
);
    import prs_pkg::*;

    if (SAMPLE_W != 24 || OFFSET_W != 16) begin : g_width_check
        $error("prs_result_regs: only 24/16-bit widths supported");
    end

    // ------------------------------------------------------------------
    // host side registers
    // ------------------------------------------------------------------
    logic [23:0] ref_q;
    logic [15:0] ofs_q;
    logic [7:0]  lp_cfg_q;
    logic [23:0] result_q;
    logic        hold_q;
    logic [7:0]  status_q;
    logic [7:0]  int_orig_q;
    logic [7:0]  q_status_q;
    logic        p_avail_q, t_avail_q, p_or_q, t_or_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    wire wr_ref_l = reg_wr && hit(reg_addr, ADDR_REF_LOW);
    wire wr_ref_m = reg_wr && hit(reg_addr, ADDR_REF_MID);
    wire wr_ref_h = reg_wr && hit(reg_addr, ADDR_REF_HIGH);
    wire wr_ofs_l = reg_wr && hit(reg_addr, ADDR_OFS_LOW);
    wire wr_ofs_h = reg_wr && hit(reg_addr, ADDR_OFS_HIGH);
    wire wr_lp    = reg_wr && hit(reg_addr, ADDR_LP_CFG);
    wire rd_high  = reg_rd && hit(reg_addr, ADDR_RES_HIGH);
    wire rd_out   = reg_rd && (hit(reg_addr, ADDR_RES_LOW)
                    || hit(reg_addr, ADDR_RES_MID) || rd_high);

    // reference bytes; software reset wins over a write
    always_ff @(posedge core_clk) begin
        if (!rst_b || software_reset) begin                    // see R22
            ref_q <= RST_REFERENCE;
        end else begin
            if (wr_ref_l) ref_q[7:0]   <= reg_wdata;           // see R1
            if (wr_ref_m) ref_q[15:8]  <= reg_wdata;           // see R1
            if (wr_ref_h) ref_q[23:16] <= reg_wdata;           // see R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ofs_q    <= RST_OFFSET;
            lp_cfg_q <= RST_LP_CFG;
        end else begin
            if (wr_ofs_l) ofs_q[7:0]  <= reg_wdata;            // see R3
            if (wr_ofs_h) ofs_q[15:8] <= reg_wdata;            // see R3
            // only the mode bit is stored; bits 7..1 read back zero
            if (wr_lp) lp_cfg_q[BIT_LOW_CURRENT_ENABLE] <= reg_wdata[BIT_LOW_CURRENT_ENABLE]; // see R4
        end
    end

    // one mode bit drives both conversion styles
    assign low_current_enable = lp_cfg_q[BIT_LOW_CURRENT_ENABLE];           // see R4 R6
    assign reference_in_use   = automatic_zeroing
                                || automatic_reference_restore; // see R2
    assign reference_pressure_bits = reference_in_use ? ref_q
                                     : 24'h000000;             // see R2

    // ------------------------------------------------------------------
    // result path
    // ------------------------------------------------------------------
    wire [23:0] ofs_ext   = {{8{ofs_q[15]}}, ofs_q};
    wire [23:0] corrected = p_measured - ofs_ext;              // see R20
    wire [23:0] relative  = p_measured - ref_q;
    // the stored reference enters the result only under zeroing or restore
    wire        use_rel   = reference_in_use;                 // see R2
    wire [23:0] new_res   = use_rel ? relative : corrected;
    wire        may_load  = !block_update_hold || !hold_q;     // see R21

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            result_q <= RST_RESULT;
            hold_q   <= 1'b0;
        end else begin
            if (p_sample_valid && may_load) result_q <= new_res; // see R19
            if (p_sample_valid && may_load) hold_q <= 1'b1;    // see R21
            else if (rd_high) hold_q <= 1'b0;                  // see R21
        end
    end
    assign pressure_result_bits = result_q;

    // ------------------------------------------------------------------
    // sample flags: events set, host read clears, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            p_avail_q <= 1'b0;
            t_avail_q <= 1'b0;
            p_or_q    <= 1'b0;
            t_or_q    <= 1'b0;
        end else begin
            if (p_sample_valid) p_avail_q <= 1'b1;             // see R17
            else if (rd_out) p_avail_q <= 1'b0;                // see R24
            if (t_sample_valid) t_avail_q <= 1'b1;             // see R16
            else if (t_data_read) t_avail_q <= 1'b0;           // see R24
            if (p_sample_valid && p_avail_q) p_or_q <= 1'b1;   // see R15
            else if (rd_out) p_or_q <= 1'b0;
            if (t_sample_valid && t_avail_q) t_or_q <= 1'b1;   // see R14
            else if (t_data_read) t_or_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // status snapshots; sample status refreshed once per OUTPUT_DATA_RATE cycle, interrupt origin and queue status every clock
    // ------------------------------------------------------------------
    wire [7:0] status_d = {2'b00, t_or_q, p_or_q, 2'b00,
                           t_avail_q, p_avail_q};              // see R23
    wire       evt_any  = pressure_low_event || pressure_high_event;
    wire [7:0] int_d    = {boot_running, 4'h0, evt_any,
                           pressure_low_event, pressure_high_event};
    wire       wm_hit   = unread_sample_count >= {1'b0, watermark_level};
    wire [7:0] q_d      = {wm_hit, queue_overwritten
                           && (unread_sample_count == 6'(QUEUE_DEPTH)),
                           unread_sample_count};               // see R13

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            status_q   <= 8'h00;
            int_orig_q <= 8'h00;
            q_status_q <= 8'h00;
        end else begin
            if (odr_tick) status_q <= status_d;                // see R18
            int_orig_q <= int_d;                               // see R8 R9 R10
            q_status_q <= q_d;                                 // see R11 R12
        end
    end

    // ------------------------------------------------------------------
    // read mux; unmapped addresses read zero
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            ADDR_REF_LOW:  reg_rdata = ref_q[7:0];
            ADDR_REF_MID:  reg_rdata = ref_q[15:8];
            ADDR_REF_HIGH: reg_rdata = ref_q[23:16];
            ADDR_OFS_LOW:  reg_rdata = ofs_q[7:0];
            ADDR_OFS_HIGH: reg_rdata = ofs_q[15:8];
            ADDR_LP_CFG:   reg_rdata = lp_cfg_q;                // see R7
            ADDR_INT_ORIG: reg_rdata = int_orig_q;
            ADDR_Q_STATUS: reg_rdata = q_status_q;
            ADDR_S_STATUS: reg_rdata = status_q;               // see R23
            ADDR_RES_LOW:  reg_rdata = result_q[7:0];
            ADDR_RES_MID:  reg_rdata = result_q[15:8];
            ADDR_RES_HIGH: reg_rdata = result_q[23:16];
            default:       reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_software_reset_ref;
        @(posedge core_clk) disable iff (!rst_b)
        software_reset |=> ref_q == RST_REFERENCE;
    endproperty
    a_software_reset_ref: assert property (p_software_reset_ref)             // see R22
        else $error("reference not reset by software reset");

    property p_avail_set;
        @(posedge core_clk) disable iff (!rst_b)
        p_sample_valid |=> p_avail_q;
    endproperty
    a_avail_set: assert property (p_avail_set)                 // see R17
        else $error("pressure available not set");

    property p_avail_clr;
        @(posedge core_clk) disable iff (!rst_b)
        (rd_out && !p_sample_valid) |=> !p_avail_q;
    endproperty
    a_avail_clr: assert property (p_avail_clr)                 // see R24
        else $error("pressure available not cleared by read");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (block_update_hold && hold_q && !rd_high) |=> $stable(result_q);
    endproperty
    a_hold: assert property (p_hold)                           // see R21
        else $error("result changed while held");

    property p_result;
        @(posedge core_clk) disable iff (!rst_b)
        (p_sample_valid && may_load && !use_rel && !differential_enable)
            |=> result_q == $past(p_measured) - $past(ofs_ext);
    endproperty
    a_result: assert property (p_result)                       // see R20
        else $error("result is not measurement minus offset");

    property p_overrun;
        @(posedge core_clk) disable iff (!rst_b)
        (p_sample_valid && p_avail_q) |=> p_or_q;
    endproperty
    a_overrun: assert property (p_overrun)                     // see R15
        else $error("pressure overrun missed");

    property p_boot;
        @(posedge core_clk) disable iff (!rst_b)
        boot_running |=> int_orig_q[BIT_BOOT_STAT];
    endproperty
    a_boot: assert property (p_boot)                           // see R8
        else $error("boot status not shown");

    property p_status_stable;
        @(posedge core_clk) disable iff (!rst_b)
        !odr_tick |=> $stable(status_q);
    endproperty
    a_status_stable: assert property (p_status_stable)         // see R18
        else $error("status changed outside OUTPUT_DATA_RATE tick");

    property p_lp_rsvd;
        @(posedge core_clk) disable iff (!rst_b)
        wr_lp |=> lp_cfg_q[7:1] == 7'h00
                  && low_current_enable == $past(reg_wdata[BIT_LOW_CURRENT_ENABLE]);
    endproperty
    a_lp_rsvd: assert property (p_lp_rsvd)                     // see R4
        else $error("low power config write wrong");
endmodule : prs_result_regs

`default_nettype wire

// >>> tb/prs_host_model.sv
// host-side model that reaches the registers by strobed bus cycles
`timescale 1ns/100ps
`default_nettype none

module prs_host_model (
    input  wire logic       core_clk,  // bus clock
    input  wire logic [7:0] reg_rdata, // read data from device
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_addr,  // register address
    output logic      [7:0] reg_wdata  // write data
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // callers touch the low-current bit only while no conversion runs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= (a == 8'h1A) ? {6'h00, 1'b0, d[0]} : d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // strobe s marks the read as consuming the data
    task automatic rd(input logic [7:0] a, input logic s,
                      output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= s;
        @(posedge core_clk);
        d = reg_rdata;
        reg_rd   <= 1'b0;
    endtask : rd
endmodule : prs_host_model

`default_nettype wire

// >>> tb/tb_prs_result_regs.sv
// self-checking bench of the pressure result and status registers
`timescale 1ns/100ps
`default_nettype none

module tb_prs_result_regs;
    import prs_pkg::*;
    logic core_clk, rst_b, reg_wr, reg_rd, software_reset, block_update_hold;
    logic automatic_zeroing, automatic_reference_restore, differential_enable;
    logic odr_tick, p_sample_valid, t_sample_valid, t_data_read, boot_running;
    logic pressure_low_event, pressure_high_event, queue_overwritten;
    logic low_current_enable, reference_in_use;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [5:0] unread_sample_count;
    logic [4:0] watermark_level;
    logic [23:0] p_measured, reference_pressure_bits, pressure_result_bits;
    int err_total = 0;
    int total_checks = 0;
    // address, write data, read-back expected
    logic [7:0] rows [10][3] = '{'{8'h15, 8'hAB, 8'hAB},
        '{8'h16, 8'hCD, 8'hCD}, '{8'h17, 8'hEF, 8'hEF}, '{8'h18, 8'h34, 8'h34},
        '{8'h19, 8'h12, 8'h12}, '{8'h1A, 8'h01, 8'h01}, '{8'h25, 8'hFF, 8'h00},
        '{8'h26, 8'hFF, 8'h00}, '{8'h28, 8'hFF, 8'h00}, '{8'h30, 8'hFF, 8'h00}};

    prs_result_regs i_prs_result_regs (
        .core_clk                    (core_clk),
        .rst_b                       (rst_b),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_rdata                   (reg_rdata),
        .software_reset              (software_reset),
        .block_update_hold           (block_update_hold),
        .automatic_zeroing           (automatic_zeroing),
        .automatic_reference_restore (automatic_reference_restore),
        .differential_enable         (differential_enable),
        .odr_tick                    (odr_tick),
        .p_sample_valid              (p_sample_valid),
        .p_measured                  (p_measured),
        .t_sample_valid              (t_sample_valid),
        .t_data_read                 (t_data_read),
        .boot_running                (boot_running),
        .pressure_low_event          (pressure_low_event),
        .pressure_high_event         (pressure_high_event),
        .unread_sample_count         (unread_sample_count),
        .watermark_level             (watermark_level),
        .queue_overwritten           (queue_overwritten),
        .low_current_enable          (low_current_enable),
        .reference_in_use            (reference_in_use),
        .reference_pressure_bits     (reference_pressure_bits),
        .pressure_result_bits        (pressure_result_bits)
    );
    prs_host_model i_prs_host_model (.core_clk(core_clk),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // one pressure sample, optionally with a temperature sample
    task automatic smp(input logic [23:0] m, input logic t);
        @(posedge core_clk);
        p_measured     <= m;
        p_sample_valid <= 1'b1;
        t_sample_valid <= t;
        @(posedge core_clk);
        p_sample_valid <= 1'b0;
        t_sample_valid <= 1'b0;
        @(negedge core_clk);
    endtask : smp

    task automatic output_data_rate;
        @(posedge core_clk);
        odr_tick <= 1'b1;
        @(posedge core_clk);
        odr_tick <= 1'b0;
    endtask : output_data_rate

    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_b, software_reset, block_update_hold, automatic_zeroing} = 4'h0;
        {automatic_reference_restore, differential_enable, odr_tick} = 3'h0;
        {p_sample_valid, t_sample_valid, t_data_read, boot_running} = 4'h0;
        {pressure_low_event, pressure_high_event, queue_overwritten} = 3'h0;
        p_measured = 24'h000000;
        unread_sample_count = 6'h00;
        watermark_level = 5'h0A;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        i_prs_host_model.rd(ADDR_REF_HIGH, 1'b0, d);
        chk(d, 24'h0);
        for (int i = 0; i < 10; i++) begin
            i_prs_host_model.wr(rows[i][0], rows[i][1]);
            i_prs_host_model.rd(rows[i][0], 1'b0, d);
            chk(d, rows[i][2]);
        end
        chk(low_current_enable, 24'h1);
        chk(reference_pressure_bits, 24'h0);
        @(posedge core_clk) automatic_zeroing <= 1'b1;
        @(negedge core_clk);
        chk(reference_pressure_bits, 24'hEFCDAB);
        chk(reference_in_use, 24'h1);
        @(posedge core_clk) automatic_zeroing <= 1'b0;
        smp(24'h100000, 1'b1);
        chk(pressure_result_bits, 24'h0FEDCC);
        i_prs_host_model.rd(ADDR_RES_HIGH, 1'b0, d);
        chk(d, 24'h0F);
        i_prs_host_model.rd(ADDR_RES_LOW, 1'b0, d);
        chk(d, 24'hCC);
        i_prs_host_model.rd(ADDR_S_STATUS, 1'b0, d);
        chk(d, 24'h00);
        smp(24'h000000, 1'b1);
        chk(pressure_result_bits, 24'hFFEDCC);
        output_data_rate();
        i_prs_host_model.rd(ADDR_S_STATUS, 1'b0, d);
        chk(d, 24'h33);
        i_prs_host_model.rd(ADDR_RES_HIGH, 1'b1, d);
        @(posedge core_clk) t_data_read <= 1'b1;
        @(posedge core_clk) t_data_read <= 1'b0;
        output_data_rate();
        i_prs_host_model.rd(ADDR_S_STATUS, 1'b0, d);
        chk(d, 24'h00);
        @(posedge core_clk) {boot_running, pressure_low_event} <= 2'b11;
        i_prs_host_model.rd(ADDR_INT_ORIG, 1'b0, d);
        chk(d, 24'h86);
        @(posedge core_clk) {boot_running, pressure_low_event} <= 2'b00;
        pressure_high_event <= 1'b1;
        i_prs_host_model.rd(ADDR_INT_ORIG, 1'b0, d);
        chk(d, 24'h05);
        @(posedge core_clk) {unread_sample_count, queue_overwritten} <= 7'h41;
        i_prs_host_model.rd(ADDR_Q_STATUS, 1'b0, d);
        chk(d, 24'hE0);
        @(posedge core_clk) unread_sample_count <= 6'h09;
        i_prs_host_model.rd(ADDR_Q_STATUS, 1'b0, d);
        chk(d, 24'h09);
        @(posedge core_clk) unread_sample_count <= 6'h0A;
        i_prs_host_model.rd(ADDR_Q_STATUS, 1'b0, d);
        chk(d, 24'h8A);
        @(posedge core_clk) block_update_hold <= 1'b1;
        i_prs_host_model.rd(ADDR_RES_HIGH, 1'b1, d);
        smp(24'h200000, 1'b0);
        smp(24'h300000, 1'b0);
        chk(pressure_result_bits, 24'h1FEDCC);
        i_prs_host_model.rd(ADDR_RES_HIGH, 1'b1, d);
        smp(24'h300000, 1'b0);
        chk(pressure_result_bits, 24'h2FEDCC);
        @(posedge core_clk) software_reset <= 1'b1;
        @(posedge core_clk) software_reset <= 1'b0;
        i_prs_host_model.rd(ADDR_REF_LOW, 1'b0, d);
        chk(d, 24'h00);
        i_prs_host_model.rd(ADDR_OFS_LOW, 1'b0, d);
        chk(d, 24'h34);
        @(posedge core_clk) {block_update_hold, differential_enable} <= 2'b01;
        i_prs_host_model.wr(ADDR_REF_LOW, 8'h10);
        @(negedge core_clk);
        chk(reference_in_use, 24'h0);
        chk(reference_pressure_bits, 24'h0);
        @(posedge core_clk) automatic_reference_restore <= 1'b1;
        @(negedge core_clk);
        chk(reference_pressure_bits, 24'h000010);
        smp(24'h000100, 1'b0);
        chk(pressure_result_bits, 24'h0000F0);
        @(posedge core_clk) rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        i_prs_host_model.rd(ADDR_OFS_HIGH, 1'b0, d);
        chk(d, 24'h00);
        i_prs_host_model.rd(ADDR_LP_CFG, 1'b0, d);
        chk(d, 24'h00);
        chk(pressure_result_bits, 24'h0);
        stop_test();
    end
endmodule : tb_prs_result_regs

`default_nettype wire
